// [core/vrpp_core.sv]
// Voltage rms, phase delay trim and active power datapath with APB registers
`timescale 1ns/10ps
module vrpp_core
    import vrpp_pkg::*;
#(
    parameter int VSMOOTH_SHIFT = 10,
    parameter int RMS_SHIFT = 12,
    parameter int PFILT_SHIFT = 12
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire vrpp_apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [23:0] current_sample_i,
    input wire logic current_valid_i,
    input wire logic [15:0] voltage_sample_i,
    input wire logic voltage_valid_i,
    output logic [23:0] voltage_rms_o,
    output logic [15:0] voltage_wave_o,
    output logic [31:0] active_power_o
);
    logic [2:0] div_q;
    logic tick4;
    logic tick8;
    logic [23:0] cur_q;
    logic [15:0] volt_q;
    logic [15:0] vmem [DLY_DEPTH];
    logic [23:0] imem [DLY_DEPTH];
    logic [5:0] wptr_q;
    logic primed_q;
    logic [5:0] tap;
    logic [5:0] vrd;
    logic [5:0] ird;
    logic signed [15:0] vdel_q;
    logic signed [23:0] idel_q;
    logic signed [31:0] vsmooth_q;
    logic signed [32:0] vsmooth_step;
    logic signed [15:0] vfilt;
    logic [15:0] vabs;
    logic [31:0] avg_q;
    logic signed [32:0] avg_step;
    logic [32:0] raw_mul;
    logic [24:0] raw_rms;
    logic signed [26:0] rms_sum;
    logic [23:0] rms_d;
    logic [23:0] rms_q;
    logic signed [39:0] pinst;
    logic signed [47:0] pfilt_q;
    logic signed [48:0] pfilt_step;
    logic signed [25:0] act;
    logic signed [38:0] gprod;
    logic signed [13:0] gain_fac;
    logic signed [31:0] pwr_d;
    logic signed [31:0] pwr_q;
    logic [11:0] offs_q;
    logic [5:0] phase_q;
    logic [11:0] gain_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic setup;
    logic wr_go;
    logic hit;
    logic [31:0] rd_mux;
    logic [5:0] phase_wr;

    // Divider: every slower rate is a one-cycle enable
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end
    assign tick4 = (div_q[1:0] == RMS_TICK);
    assign tick8 = (div_q == PHASE_TICK);

    // Hold the newest sample of each channel
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cur_q <= 24'h00_0000;
        end else if (current_valid_i) begin
            cur_q <= current_sample_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            volt_q <= 16'h0000;
        end else if (voltage_valid_i) begin
            volt_q <= voltage_sample_i;
        end
    end

    // Delay lines advance once per phase step; no reset, contents are history
    always_ff @(posedge clock_i) begin
        if (tick8) begin
            vmem[wptr_q] <= volt_q;
            imem[wptr_q] <= cur_q;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_q <= 6'h00;
        end else if (tick8) begin
            wptr_q <= wptr_q + 6'h01;
        end
    end

    // Voltage tap moves with the trim; current sits at the zero-delay tap,
    // so a smaller code reads a newer voltage sample, i.e. a time advance
    assign tap = phase_q + PHASE_BIAS;
    assign vrd = wptr_q - 6'h01 - tap;
    assign ird = wptr_q - 6'h01 - PHASE_ZERO_TAP;

    // Until every slot has been written once the taps would read unknown
    // history, which the recursive filters would then keep for ever
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            primed_q <= 1'b0;
        end else if (tick8 && wptr_q == 6'(DLY_DEPTH - 1)) begin
            primed_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            vdel_q <= 16'sh0000;
            idel_q <= 24'sh00_0000;
        end else if (tick8) begin
            vdel_q <= primed_q ? $signed(vmem[vrd]) : 16'sh0000;
            idel_q <= primed_q ? $signed(imem[ird]) : 24'sh00_0000;
        end
    end

    // Single-pole low-pass on the voltage, 16 fraction bits of headroom;
    // the step is one bit wider so a full-scale swing cannot wrap
    assign vsmooth_step = $signed({vdel_q[15], vdel_q, 16'h0000}) - 33'(vsmooth_q);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            vsmooth_q <= 32'sh0000_0000;
        end else if (tick4) begin
            vsmooth_q <= vsmooth_q + 32'(vsmooth_step >>> VSMOOTH_SHIFT);
        end
    end
    assign vfilt = vsmooth_q[31:16];

    // Mean absolute value of the filtered voltage, no square or root needed
    assign vabs = vfilt[15] ? 16'(-vfilt) : 16'(vfilt);
    assign avg_step = $signed({1'b0, vabs, 16'h0000}) - $signed({1'b0, avg_q});

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            avg_q <= 32'h0000_0000;
        end else if (tick4) begin
            avg_q <= avg_q + 32'(avg_step >>> RMS_SHIFT);
        end
    end

    // Scale mean absolute to rms; the fixed factor also absorbs the
    // sine form factor so a full-scale 60 Hz input lands near 1,561,400
    assign raw_mul = 33'(avg_q[31:8]) * 33'(RMS_SCALE);
    assign raw_rms = raw_mul[32:8];
    assign rms_sum = $signed({2'b00, raw_rms}) + 27'(signed'(offs_q));

    // Clamp to the unsigned 24-bit result range
    always_comb begin
        if (rms_sum < 0) begin
            rms_d = 24'h00_0000;
        end else if (rms_sum > $signed({3'b000, RMS_MAX})) begin
            rms_d = RMS_MAX;
        end else begin
            rms_d = rms_sum[23:0];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rms_q <= 24'h00_0000;
        end else if (tick4) begin
            rms_q <= rms_d;
        end
    end

    // Power uses the unfiltered, phase-trimmed voltage
    assign pinst = idel_q * vdel_q;
    assign pfilt_step = $signed({pinst, 8'h00}) - 49'(pfilt_q);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pfilt_q <= 48'sh0000_0000_0000;
        end else if (tick4) begin
            pfilt_q <= pfilt_q + 48'(pfilt_step >>> PFILT_SHIFT);
        end
    end

    // Gain word scales by (4096 + gain) / 4096; the factor runs up to
    // 6143, so it takes 14 bits to stay positive as a signed operand
    assign gain_fac = $signed(14'(GAIN_UNITY) + 14'(signed'(gain_q)));
    assign act = pfilt_q[47:22];
    assign gprod = act * gain_fac;
    assign pwr_d = 32'(gprod >>> GAIN_SHIFT);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_q <= 32'sh0000_0000;
        end else if (tick4) begin
            pwr_q <= pwr_d;
        end
    end

    // APB decode; zero wait states, read data staged in the setup cycle
    assign setup = apb_i.psel && !apb_i.penable;
    assign wr_go = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign pready_o = 1'b1;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (apb_i.paddr)
            ADDR_RMS: rd_mux = {8'h00, rms_q};
            ADDR_OFFS: rd_mux = {20'h0_0000, offs_q};
            ADDR_PHASE: rd_mux = {26'h000_0000, phase_q};
            ADDR_GAIN: rd_mux = {20'h0_0000, gain_q};
            ADDR_POWER: rd_mux = pwr_q;
            ADDR_WAVE: rd_mux = {16'h0000, vfilt};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= apb_i.pwrite ? 32'h0000_0000 : rd_mux;
            slverr_q <= !hit;
        end
    end
    assign prdata_o = prdata_q;
    assign pslverr_o = slverr_q;

    // The one code outside the legal span is pulled in to the nearest end
    assign phase_wr = (apb_i.pwdata[5:0] == PHASE_BAD) ? PHASE_MIN : apb_i.pwdata[5:0];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= PHASE_RST;
        end else if (wr_go && apb_i.paddr == ADDR_PHASE) begin
            phase_q <= phase_wr;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            offs_q <= OFFS_RST;
        end else if (wr_go && apb_i.paddr == ADDR_OFFS) begin
            offs_q <= apb_i.pwdata[11:0];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gain_q <= GAIN_RST;
        end else if (wr_go && apb_i.paddr == ADDR_GAIN) begin
            gain_q <= apb_i.pwdata[11:0];
        end
    end

    assign voltage_rms_o = rms_q;
    assign voltage_wave_o = vfilt;
    assign active_power_o = pwr_q;

    // Checks on the datapath timing and scaling
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence phase_gap_s;
        !tick8 [*7] ##1 tick8;
    endsequence

    sequence quarter_gap_s;
        !tick4 [*3] ##1 tick4;
    endsequence

    step_rate_a: assert property (tick8 |=> phase_gap_s)
        else $error("phase step enable not every eighth clock");

    rms_rate_a: assert property (tick4 |=> quarter_gap_s)
        else $error("rms update enable not every fourth clock");

    rms_hold_a: assert property (!tick4 |=> $stable(rms_q))
        else $error("rms result moved between updates");

    rms_offset_a: assert property (tick4 && rms_sum >= 0 && rms_sum <= 27'sh0FF_FFFF
        |=> rms_q == $past(raw_rms[23:0]) + $past(offs_q[11] ? {12'hFFF, offs_q}
        : {12'h000, offs_q}))
        else $error("rms result is not estimate plus offset");

    rms_floor_a: assert property (tick4 && rms_sum < 0 |=> rms_q == 24'h00_0000)
        else $error("negative rms not clamped to zero");

    phase_legal_a: assert property (phase_q != PHASE_BAD)
        else $error("phase trim holds an illegal code");

    phase_tap_a: assert property (phase_q == PHASE_RST |-> vrd == ird)
        else $error("zero-delay code does not align channels");

    phase_lead_a: assert property (tick8 && primed_q
        |=> vdel_q == $signed($past(vmem[vrd])))
        else $error("voltage tap not taken from trimmed position");

    gain_unity_a: assert property (tick4 && gain_q == GAIN_RST
        |=> pwr_q == 32'($past(act)))
        else $error("zero gain word changed power");

    gain_apply_a: assert property (tick4 ##1 !tick4 [*3]
        |-> pwr_q == 32'((40'($past(act, 3)) * (40'(signed'($past(gain_q, 3)))
        + $signed(40'(GAIN_UNITY)))) >>> GAIN_SHIFT))
        else $error("power readout lacks gain scaling");

    apb_phase_a: assert property (wr_go && apb_i.paddr == ADDR_PHASE
        && apb_i.pwdata[5:0] != PHASE_BAD |=> phase_q == $past(apb_i.pwdata[5:0]))
        else $error("phase trim write lost");

    // Fill gate, pointer, power hold, gain factor and phase clamp
    prime_gate_a: assert property (!primed_q
        |-> vdel_q == 16'sh0000 && idel_q == 24'sh00_0000)
        else $error("delay taps read before the line was filled");

    ptr_step_a: assert property (tick8 |=> wptr_q == $past(wptr_q) + 6'h01)
        else $error("delay line pointer did not advance by one");

    power_hold_a: assert property (!tick4 |=> $stable(pwr_q))
        else $error("power result moved between updates");

    gain_range_a: assert property (gain_fac >= 14'sd2048 && gain_fac <= 14'sd6143)
        else $error("gain factor outside half to one and a half");

    phase_clamp_a: assert property (wr_go && apb_i.paddr == ADDR_PHASE
        && apb_i.pwdata[5:0] == PHASE_BAD |=> phase_q == PHASE_MIN)
        else $error("illegal phase code not pulled to the nearest end");
endmodule

// [shared/vrpp_pkg.sv]
// Constants and carrier types for the voltage rms, phase and power block
// Functional notes
// - Voltage rms from mean absolute value
// - Rms taken from smoothed voltage samples
// - Rms result is unsigned 24 bits
// - Rms result refreshed every fourth clock
// - Full-scale sine reads about 1,561,400
// - Rms offset trim is 12-bit signed
// - Rms result is estimate plus offset
// - Phase trim spans 0x21 to 0x1F
// - Phase code 0x0D gives zero delay
// - One phase step is eight clocks
// - Phase trim moves voltage path only
// - Phase lead is a shorter delay
// - Instantaneous power is current times voltage
// - Low-pass filter extracts active power
// - Power scaled by one plus gain/4096
// - Gain step 0.0244%, range +-50%
// - Readout power already carries gain
// - Voltage samples pass single-pole low-pass
package vrpp_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_RMS = 8'h00;
    localparam logic [7:0] ADDR_OFFS = 8'h04;
    localparam logic [7:0] ADDR_PHASE = 8'h08;
    localparam logic [7:0] ADDR_GAIN = 8'h0C;
    localparam logic [7:0] ADDR_POWER = 8'h10;
    localparam logic [7:0] ADDR_WAVE = 8'h14;
    // Reset values
    localparam logic [11:0] OFFS_RST = 12'h000;
    localparam logic [5:0] PHASE_RST = 6'h0D;
    localparam logic [11:0] GAIN_RST = 12'h000;
    // Phase trim coding
    localparam logic [5:0] PHASE_BAD = 6'h20;
    localparam logic [5:0] PHASE_MIN = 6'h21;
    localparam logic [5:0] PHASE_BIAS = 6'h1F;
    localparam logic [5:0] PHASE_ZERO_TAP = 6'h2C;
    localparam int DLY_DEPTH = 64;
    // Rates, as the divider count at which each update enable fires
    localparam logic [1:0] RMS_TICK = 2'h3;
    localparam logic [2:0] PHASE_TICK = 3'h7;
    // Rms scaling and limits
    localparam logic [8:0] RMS_SCALE = 9'h102;
    localparam logic [23:0] RMS_MAX = 24'hFF_FFFF;
    localparam int RMS_W = 24;
    // Power scaling
    localparam int POWER_SHIFT = 14;
    localparam int GAIN_SHIFT = 12;
    localparam logic [12:0] GAIN_UNITY = 13'h1000;

    // APB request as it arrives from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } vrpp_apb_req_t;
endpackage

// [sim/tb.sv]
// Self-checking bench for the voltage rms, phase trim and power block
`timescale 1ns/10ps
module tb;
    import vrpp_pkg::*;
    localparam logic [7:0] WA [5] = '{ADDR_OFFS, ADDR_GAIN, ADDR_GAIN, ADDR_PHASE, ADDR_PHASE};
    localparam logic [31:0] WD [5] = '{32'hFFFF_FFFF, 32'h0000_0800, 32'h0000_0000,
        32'h0000_0020, 32'h0000_001F};
    localparam logic [31:0] WE [5] = '{32'h0000_0FFF, 32'h0000_0800, 32'h0000_0000,
        32'h0000_0021, 32'h0000_001F};
    logic clk = 1'b0;
    logic rst = 1'b1;
    vrpp_apb_req_t apb = '0;
    logic [23:0] cur = 24'h00_0000;
    logic [15:0] volt = 16'h0000;
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [23:0] rms_o;
    logic [15:0] wave_o;
    logic [31:0] pwr_o;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int ta;
    int tb_;
    int tc;

    // Short filter constants keep settling within a few thousand clocks
    vrpp_core #(.VSMOOTH_SHIFT(4), .RMS_SHIFT(4), .PFILT_SHIFT(4)) vrpp_core_inst (
        .clock_i(clk), .rst_i(rst), .apb_i(apb), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .current_sample_i(cur),
        .current_valid_i(1'b1), .voltage_sample_i(volt), .voltage_valid_i(1'b1),
        .voltage_rms_o(rms_o), .voltage_wave_o(wave_o), .active_power_o(pwr_o));

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // One APB transfer; an idle edge after release avoids double assignment
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) n_mismatch++;
        rdata = prdata_o;
        rerr = pslverr_o;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Filters truncate, so settled values are compared with a tolerance
    task automatic near(input string nm, input int e, input logic [31:0] g, input int tol);
        int d;
        d = $signed(g) - e;
        checks_done++;
        if ($isunknown(g) || d > tol || d < -tol) begin
            n_mismatch++;
            $display("FAIL %s expected %0d seen %0d", nm, e, $signed(g));
        end
    endtask

    task automatic t_regs();
        xfer(0, ADDR_PHASE, 0);
        chk("phase_rst", {26'h0, PHASE_RST}, rdata);
        xfer(0, ADDR_GAIN, 0);
        chk("gain_rst", {20'h0, GAIN_RST}, rdata);
        for (int i = 0; i < 5; i++) begin
            xfer(1, WA[i], WD[i]);
            xfer(0, WA[i], 0);
            chk("rw_reg", WE[i], rdata);
        end
        xfer(1, ADDR_PHASE, {26'h0, PHASE_RST});
        xfer(0, 8'h18, 0);
        chk("unmapped_err", 32'h0000_0001, {31'h0, rerr});
        chk("unmapped_data", 32'h0000_0000, rdata);
    endtask

    // Zero input makes the estimate zero, so the result shows the trim alone;
    // with no signal every read falls on a zero crossing
    task automatic t_rms();
        xfer(1, ADDR_OFFS, 32'h0000_0005);
        xfer(1, ADDR_RMS, 32'h0000_1234);
        repeat (16) @(posedge clk);
        chk("rms_out", 32'h0000_0005, {8'h0, rms_o});
        xfer(0, ADDR_RMS, 0);
        chk("rms_reg", 32'h0000_0005, rdata);
        xfer(1, ADDR_OFFS, 32'h0000_0FFB);
        repeat (16) @(posedge clk);
        chk("rms_floor", 32'h0000_0000, {8'h0, rms_o});
        xfer(1, ADDR_OFFS, 32'h0000_0000);
    endtask

    // Settled rms at one dc level, read with the trim at 0 and then at 32
    task automatic rms_at(input logic [15:0] v, output int r0, output int r1);
        volt <= v;
        xfer(1, ADDR_OFFS, 32'h0000_0000);
        repeat (3000) @(posedge clk);
        xfer(0, ADDR_RMS, 0);
        r0 = rdata;
        xfer(1, ADDR_OFFS, 32'h0000_0020);
        repeat (16) @(posedge clk);
        xfer(0, ADDR_RMS, 0);
        r1 = rdata;
    endtask

    // Two-level calibration: the offset derived from a quarter-scale and a
    // low reading must match the trim within one count; mean absolute ignores sign
    task automatic t_cal();
        int a0, a1, b0, b1, d;
        rms_at(16'h2000, a0, a1);
        near("rms_full", 2113536, a0, 600);
        chk("rms_trim", 32'd32, a1 - a0);
        rms_at(16'h0200, b0, b1);
        d = ((b1 - b0) * 8192 - (a1 - a0) * 512) / 7680;
        near("cal_offset", 32, d, 1);
        rms_at(16'hE000, b0, b1);
        near("rms_negative", a0, b0, 600);
        xfer(1, ADDR_OFFS, 32'h0000_0000);
    endtask

    // Clocks from a voltage step, aligned to the 8-clock grid, to power rising
    task automatic arrival(input logic [5:0] code, output int t);
        xfer(1, ADDR_PHASE, {26'h0, code});
        volt <= 16'h0000;
        repeat (3000) @(posedge clk);
        near("power_idle", 0, pwr_o, 1000);
        while (cyc % 8 != 0) @(posedge clk);
        volt <= 16'h2000;
        t = 0;
        while ($signed(pwr_o) < 16384 && t < 2000) begin
            @(posedge clk);
            t++;
        end
    endtask

    task automatic t_phase();
        cur <= 24'h10_0000;
        arrival(6'h0D, ta);
        arrival(6'h0F, tb_);
        arrival(6'h0B, tc);
        chk("phase_delay", 32'd16, tb_ - ta);
        chk("phase_lead", 32'd16, ta - tc);
    endtask

    // 2^20 times 2^13 shifted by 14 gives 2^19 before gain
    task automatic t_power();
        xfer(1, ADDR_PHASE, {26'h0, PHASE_RST});
        repeat (3000) @(posedge clk);
        near("wave", 32'h2000, {{16{wave_o[15]}}, wave_o}, 2);
        xfer(0, ADDR_WAVE, 0);
        near("wave_reg", 32'h2000, {{16{rdata[15]}}, rdata[15:0]}, 2);
        near("power_unity", 524288, pwr_o, 64);
        xfer(1, ADDR_GAIN, 32'h0000_07FF);
        repeat (100) @(posedge clk);
        near("power_max", 786304, pwr_o, 96);
        xfer(0, ADDR_POWER, 0);
        near("power_reg", 786304, rdata, 96);
        xfer(1, ADDR_GAIN, 32'h0000_0800);
        repeat (100) @(posedge clk);
        near("power_min", 262144, pwr_o, 32);
        xfer(1, ADDR_GAIN, 32'h0000_0000);
        volt <= 16'hE000;
        repeat (3000) @(posedge clk);
        near("power_neg", -524288, pwr_o, 64);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 25500 clocks the run needs
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_rms();
        t_cal();
        t_phase();
        t_power();
        print_verdict();
    end
endmodule
